/* File: inc/menu_pkg.sv */
package menu_pkg;
    // Command values reported to the remote station, one per menu or function
    localparam logic [7:0] CMD_LOGO = 8'h01;
    localparam logic [7:0] CMD_MAIN = 8'h02;
    localparam logic [7:0] CMD_SET = 8'h03;
    localparam logic [7:0] CMD_PROGRAM = 8'h07;
    localparam logic [7:0] CMD_UTILITY = 8'h0b;
    localparam logic [7:0] CMD_STATUS = 8'h0c;
    localparam logic [7:0] CMD_LOCK = 8'h0d;
    // Serial characters
    localparam logic [7:0] CHAR_ONE = 8'h31;
    localparam logic [7:0] CHAR_FOUR = 8'h34;
    localparam logic [7:0] CHAR_THREE = 8'h33;
    localparam logic [7:0] CHAR_SYNC = 8'h35;
    // Timing, clock 250 MHz
    localparam int CLK_MHZ = 250;
    localparam int STATUS_MS = 2000;
    localparam int STATUS_CYCLES = STATUS_MS * 1000 * CLK_MHZ;
    localparam int LOGO_MS = 500;
    localparam int LOGO_CYCLES = LOGO_MS * 1000 * CLK_MHZ;
    localparam int DEBOUNCE_US = 10000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int BEEP_MS = 150;
    localparam int BEEP_CYCLES = BEEP_MS * 1000 * CLK_MHZ;
    localparam int TONE_US = 500;
    localparam int TONE_CYCLES = TONE_US * CLK_MHZ;
    localparam int BEEP_COUNT = 3;

    typedef enum logic [2:0] {
        ST_LOGO = 3'b000,
        ST_MAIN = 3'b001,
        ST_SET = 3'b010,
        ST_PROGRAM = 3'b011,
        ST_UTILITY = 3'b100,
        ST_STATUS = 3'b101
    } menu_state_t;

    typedef enum logic [1:0] {
        SCR_TEMP = 2'b00,
        SCR_MODE = 2'b01,
        SCR_LINK = 2'b10,
        SCR_CHARS = 2'b11
    } status_screen_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_msg_t;

    typedef struct packed {
        logic [2:0] menu;
        logic [1:0] screen;
        logic locked;
    } display_t;
endpackage

/* File: hw/key_debounce.sv */
`timescale 1ns/10ps
module key_debounce #(
    parameter int HOLD_CYCLES = menu_pkg::DEBOUNCE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic key_raw,
    output logic press_pulse
);
    typedef struct packed {
        logic stable;
        logic [31:0] count;
        logic pulse;
    } deb_state_t;

    deb_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        // High level is a press; level must hold before it counts
        if (key_raw == s_q.stable) begin
            s_d.count = 32'h0;
        end else if (s_q.count >= 32'(HOLD_CYCLES - 1)) begin
            s_d.count = 32'h0;
            s_d.stable = key_raw;
            s_d.pulse = key_raw;
        end else begin
            s_d.count = s_q.count + 32'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign press_pulse = s_q.pulse;
endmodule

/* File: hw/beep_gen.sv */
`timescale 1ns/10ps
module beep_gen #(
    parameter int BEEP_LEN = menu_pkg::BEEP_CYCLES,
    parameter int HALF_TONE = menu_pkg::TONE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    output logic speaker,
    output logic busy
);
    typedef struct packed {
        logic [2:0] phases;
        logic [31:0] count;
        logic [31:0] tone;
        logic spk;
    } beep_state_t;

    beep_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (s_q.phases == 3'h0) begin
            s_d.spk = 1'b0;
            if (start) begin
                // Three beeps with two gaps between them
                s_d.phases = 3'(2 * menu_pkg::BEEP_COUNT - 1);
                s_d.count = 32'h0;
                s_d.tone = 32'h0;
            end
        end else begin
            if (s_q.count >= 32'(BEEP_LEN - 1)) begin
                s_d.count = 32'h0;
                s_d.phases = s_q.phases - 3'h1;
                s_d.spk = 1'b0;
            end else begin
                s_d.count = s_q.count + 32'h1;
            end
            if (s_q.phases[0]) begin
                if (s_q.tone >= 32'(HALF_TONE - 1)) begin
                    s_d.tone = 32'h0;
                    s_d.spk = ~s_q.spk;
                end else begin
                    s_d.tone = s_q.tone + 32'h1;
                end
            end else begin
                s_d.spk = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign speaker = s_q.spk;
    assign busy = (s_q.phases != 3'h0);
endmodule

/* File: hw/keypad_serial_menu_interpreter.sv */
`timescale 1ns/10ps
module keypad_serial_menu_interpreter #(
    parameter int STATUS_LEN = menu_pkg::STATUS_CYCLES,
    parameter int LOGO_PERIOD = menu_pkg::LOGO_CYCLES,
    parameter int DEBOUNCE_LEN = menu_pkg::DEBOUNCE_CYCLES,
    parameter int BEEP_LEN = menu_pkg::BEEP_CYCLES,
    parameter int HALF_TONE = menu_pkg::TONE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] button,
    input wire menu_pkg::byte_msg_t rx_char,
    input wire logic tx_ready,
    output menu_pkg::byte_msg_t tx_char,
    output menu_pkg::display_t display,
    output logic speaker
);
    typedef struct packed {
        menu_pkg::menu_state_t menu;
        menu_pkg::status_screen_t screen;
        logic locked;
        logic [31:0] timer;
        logic tx_pending;
        logic [7:0] tx_value;
        menu_pkg::byte_msg_t tx;
        menu_pkg::display_t disp;
        logic beep_start;
        logic spk;
    } top_state_t;

    top_state_t s_q, s_d;
    logic [3:0] press;
    logic beep_out;
    logic beep_busy;
    logic [2:0] key_num;
    logic key_valid;
    logic sync_req;
    logic from_serial;

    for (genvar i = 0; i < 4; i++) begin : g_deb
        key_debounce #(
            .HOLD_CYCLES(DEBOUNCE_LEN)
        ) u_deb (
            .core_clk(core_clk),
            .rst(rst),
            .key_raw(button[i]),
            .press_pulse(press[i])
        );
    end

    beep_gen #(
        .BEEP_LEN(BEEP_LEN),
        .HALF_TONE(HALF_TONE)
    ) u_beep (
        .core_clk(core_clk),
        .rst(rst),
        .start(s_q.beep_start),
        .speaker(beep_out),
        .busy(beep_busy)
    );

    function automatic logic [7:0] cmd_of(input menu_pkg::menu_state_t m, input logic lk);
        // Distinct value per menu and function
        case (m)
            menu_pkg::ST_LOGO: cmd_of = menu_pkg::CMD_LOGO;
            menu_pkg::ST_MAIN: cmd_of = menu_pkg::CMD_MAIN;
            menu_pkg::ST_SET: cmd_of = menu_pkg::CMD_SET;
            menu_pkg::ST_PROGRAM: cmd_of = menu_pkg::CMD_PROGRAM;
            menu_pkg::ST_UTILITY: cmd_of = lk ? menu_pkg::CMD_LOCK : menu_pkg::CMD_UTILITY;
            menu_pkg::ST_STATUS: cmd_of = menu_pkg::CMD_STATUS;
            default: cmd_of = menu_pkg::CMD_LOGO;
        endcase
    endfunction

    // Merge the two input sources into one key event
    always_comb begin
        key_num = 3'h0;
        key_valid = 1'b0;
        sync_req = 1'b0;
        from_serial = 1'b0;
        if (press != 4'h0) begin
            key_valid = 1'b1;
            // Lowest button wins if two settle in the same cycle
            if (press[0]) begin
                key_num = 3'h1;
            end else if (press[1]) begin
                key_num = 3'h2;
            end else if (press[2]) begin
                key_num = 3'h3;
            end else begin
                key_num = 3'h4;
            end
        end else if (rx_char.valid) begin
            if (rx_char.data >= menu_pkg::CHAR_ONE && rx_char.data <= menu_pkg::CHAR_FOUR) begin
                key_valid = 1'b1;
                from_serial = 1'b1;
                key_num = 3'(rx_char.data - menu_pkg::CHAR_ONE) + 3'h1;
            end else if (rx_char.data == menu_pkg::CHAR_SYNC) begin
                sync_req = 1'b1;
            end
            // Anything else falls through unused
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.beep_start = 1'b0;
        s_d.spk = beep_out;
        if (s_q.tx.valid && tx_ready) begin
            s_d.tx.valid = 1'b0;
        end
        if (s_q.timer != 32'h0) begin
            s_d.timer = s_q.timer - 32'h1;
        end

        case (s_q.menu)
            menu_pkg::ST_LOGO: begin
                if (key_valid) begin
                    s_d.menu = menu_pkg::ST_MAIN;
                    s_d.tx_pending = 1'b1;
                end else if (s_q.timer == 32'h0) begin
                    // Repeat announce; a busy link holds it pending until the slot frees
                    s_d.timer = 32'(LOGO_PERIOD - 1);
                    s_d.tx_pending = 1'b1;
                end
            end
            menu_pkg::ST_MAIN: begin
                if (key_valid) begin
                    s_d.tx_pending = 1'b1;
                    case (key_num)
                        3'h1: s_d.menu = menu_pkg::ST_SET;
                        3'h2: s_d.menu = menu_pkg::ST_PROGRAM;
                        3'h3: s_d.menu = menu_pkg::ST_UTILITY;
                        default: s_d.menu = menu_pkg::ST_LOGO;
                    endcase
                end
            end
            menu_pkg::ST_SET, menu_pkg::ST_PROGRAM: begin
                // Submenus are outside this block; button four backs out
                if (key_valid && key_num == 3'h4) begin
                    s_d.menu = menu_pkg::ST_MAIN;
                    s_d.tx_pending = 1'b1;
                end
            end
            menu_pkg::ST_UTILITY: begin
                if (key_valid && key_num == 3'h2) begin
                    s_d.locked = ~s_q.locked;
                    s_d.tx_pending = 1'b1;
                end else if (key_valid && !s_q.locked) begin
                    if (key_num == 3'h1) begin
                        s_d.menu = menu_pkg::ST_STATUS;
                        s_d.screen = menu_pkg::SCR_TEMP;
                        s_d.timer = 32'(STATUS_LEN - 1);
                        s_d.tx_pending = 1'b1;
                    end else if (key_num == 3'h3) begin
                        if (from_serial && !beep_busy) begin
                            s_d.beep_start = 1'b1;
                        end
                    end else begin
                        s_d.menu = menu_pkg::ST_MAIN;
                        s_d.tx_pending = 1'b1;
                    end
                end
            end
            menu_pkg::ST_STATUS: begin
                // Screens run on their own; key presses are not taken meanwhile, a sync still resends
                if (s_q.timer == 32'h0) begin
                    if (s_q.screen == menu_pkg::SCR_CHARS) begin
                        s_d.menu = menu_pkg::ST_UTILITY;
                        s_d.tx_pending = 1'b1;
                    end else begin
                        s_d.screen = menu_pkg::status_screen_t'(s_q.screen + 2'h1);
                        s_d.timer = 32'(STATUS_LEN - 1);
                    end
                end
            end
            default: begin
                s_d.menu = menu_pkg::ST_LOGO;
            end
        endcase

        if (sync_req) begin
            s_d.tx_pending = 1'b1;
        end
        if (s_d.menu != menu_pkg::ST_LOGO && s_q.menu == menu_pkg::ST_LOGO) begin
            s_d.timer = 32'h0;
        end

        // Send the value of the state being entered, latest wins
        s_d.tx_value = cmd_of(s_d.menu, s_d.locked);
        if (s_d.tx_pending && !s_d.tx.valid) begin
            s_d.tx.valid = 1'b1;
            s_d.tx.data = s_d.tx_value;
            s_d.tx_pending = 1'b0;
        end

        s_d.disp.menu = s_d.menu;
        s_d.disp.screen = s_d.screen;
        s_d.disp.locked = s_d.locked;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.tx_value <= menu_pkg::CMD_LOGO;
        end else begin
            s_q <= s_d;
        end
    end

    assign tx_char = s_q.tx;
    assign display = s_q.disp;
    assign speaker = s_q.spk;
endmodule

/* File: verif/menu_props.sv */
`timescale 1ns/10ps
module menu_props #(
    parameter int STATUS_LEN = 20,
    parameter int LOGO_PERIOD = 30
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] button,
    input wire menu_pkg::byte_msg_t rx_char,
    input wire logic tx_ready,
    input wire menu_pkg::byte_msg_t tx_char,
    input wire menu_pkg::display_t display,
    input wire logic speaker
);
    localparam int LOGO_WIN = LOGO_PERIOD + 10;
    logic [7:0] stay_q;
    menu_pkg::display_t disp_q;
    always_ff @(posedge core_clk) begin
        disp_q <= display;
        stay_q <= (display == disp_q) ? stay_q + 8'h01 : 8'h00;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Six idle cycles leave no debounced press pending
    sequence quiet;
        (button == 4'h0)[*6];
    endsequence
    sequence got_char(logic [7:0] c);
        rx_char.valid && rx_char.data == c;
    endsequence
    a_tx_holds_byte: assert property (tx_char.valid && !tx_ready |=>
        tx_char.valid && $stable(tx_char.data)) else $error("tx byte dropped");
    a_sync_keeps_menu: assert property (quiet ##1 got_char(menu_pkg::CHAR_SYNC)
        ##0 display.menu != menu_pkg::ST_STATUS |=> $stable(display)) else $error("sync moved");
    a_logo_key_exit: assert property (quiet ##1 (rx_char.valid && display.menu ==
        menu_pkg::ST_LOGO && rx_char.data inside {[8'h31:8'h34]}) |=>
        display.menu == menu_pkg::ST_MAIN) else $error("logo not left");
    a_lock_ignores_keys: assert property (quiet ##1 (display.locked && rx_char.valid
        && rx_char.data != 8'h32) |=> $stable(display)) else $error("locked menu moved");
    a_enter_sends_value: assert property ($changed(display.menu) && !$past(tx_char.valid)
        && display.menu inside {menu_pkg::ST_MAIN, menu_pkg::ST_UTILITY} |-> ##[0:1]
        (tx_char.valid && tx_char.data == ((display.menu == menu_pkg::ST_MAIN) ?
        menu_pkg::CMD_MAIN : menu_pkg::CMD_UTILITY))) else $error("entry value missing");
    a_screen_span: assert property (disp_q.menu == menu_pkg::ST_STATUS && display != disp_q
        |-> stay_q == STATUS_LEN - 1) else $error("status screen length");
    a_status_return: assert property (disp_q.menu == menu_pkg::ST_STATUS &&
        display.menu != menu_pkg::ST_STATUS |-> display.menu == menu_pkg::ST_UTILITY
        && disp_q.screen == menu_pkg::SCR_CHARS) else $error("status exit");
    a_beep_starts: assert property ((button == 4'h0 && !speaker)[*8] ##1
        (button == 4'h0 && !speaker)[*8] ##1 got_char(menu_pkg::CHAR_THREE) ##0
        (display.menu == menu_pkg::ST_UTILITY && !display.locked) |-> ##[1:6] speaker)
        else $error("no beep");
    a_logo_repeats: assert property ($fell(tx_char.valid) && display.menu ==
        menu_pkg::ST_LOGO |-> ##[1:LOGO_WIN] (tx_char.valid ||
        display.menu != menu_pkg::ST_LOGO)) else $error("logo value not repeated");
endmodule
bind keypad_serial_menu_interpreter menu_props #(.STATUS_LEN(STATUS_LEN),
    .LOGO_PERIOD(LOGO_PERIOD)) u_props (.core_clk(core_clk), .rst(rst), .button(button),
    .rx_char(rx_char), .tx_ready(tx_ready), .tx_char(tx_char), .display(display),
    .speaker(speaker));

/* File: verif/remote_station.sv */
`timescale 1ns/10ps
module remote_station (
    input wire logic core_clk,
    input wire logic slow,
    input wire menu_pkg::byte_msg_t tx_char,
    output logic tx_ready,
    output menu_pkg::byte_msg_t rx_char
);
    logic [7:0] got[$];
    int held = 0;
    initial begin
        tx_ready = 1'b0;
        rx_char = '0;
    end
    // Slow mode stalls each byte so the pending slot is exercised
    always @(posedge core_clk) begin
        if (tx_char.valid && tx_ready) begin
            got.push_back(tx_char.data);
        end
        held = (tx_char.valid && !tx_ready) ? held + 1 : 0;
        tx_ready <= tx_char.valid && !tx_ready && (!slow || held > 6);
    end
    // Data lines show junk once the strobe is gone
    task automatic send(input logic [7:0] c);
        @(posedge core_clk);
        rx_char <= '{valid: 1'b1, data: c};
        @(posedge core_clk);
        rx_char <= '{valid: 1'b0, data: ~c};
    endtask
endmodule

/* File: verif/tb_keypad_serial_menu_interpreter.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_keypad_serial_menu_interpreter;
    logic core_clk, rst, slow, tx_ready, speaker;
    logic [3:0] button;
    menu_pkg::byte_msg_t rx_char, tx_char;
    menu_pkg::display_t display;
    int err_total = 0;
    int check_count = 0;
    // Shortened timings so the whole run stays brief
    localparam int T_STATUS = 20;
    localparam int T_LOGO = 30;
    localparam int T_DEB = 3;
    localparam int T_BEEP = 10;
    localparam int T_TONE = 2;
    keypad_serial_menu_interpreter #(.STATUS_LEN(T_STATUS), .LOGO_PERIOD(T_LOGO),
        .DEBOUNCE_LEN(T_DEB), .BEEP_LEN(T_BEEP), .HALF_TONE(T_TONE)) uut (
        .core_clk(core_clk), .rst(rst), .button(button),
        .rx_char(rx_char), .tx_ready(tx_ready), .tx_char(tx_char), .display(display),
        .speaker(speaker));
    remote_station st (.core_clk(core_clk), .slow(slow), .tx_char(tx_char),
        .tx_ready(tx_ready), .rx_char(rx_char));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic press(input int k);
        @(posedge core_clk);
        button[k] <= 1'b1;
        cyc(8);
        @(posedge core_clk);
        button[k] <= 1'b0;
        cyc(8);
    endtask
    task automatic key(input int k, input bit ser);
        if (ser) begin
            st.send(8'h30 + 8'(k));
            cyc(8);
        end else begin
            press(k - 1);
        end
    endtask
    task automatic expect_tx(input int n0, input logic [7:0] v);
        for (int t = 0; t < 200 && !(st.got.size() > n0 && st.got[$] === v); t++) begin
            cyc(1);
        end
        `CHK("tx", v, st.got[$])
    endtask
    task automatic t_logo();
        int n;
        expect_tx(0, menu_pkg::CMD_LOGO);
        n = st.got.size();
        expect_tx(n, menu_pkg::CMD_LOGO);
        n = st.got.size();
        press(1);
        expect_tx(n, menu_pkg::CMD_MAIN);
        `CHK("menu", menu_pkg::ST_MAIN, display.menu)
        n = st.got.size();
        cyc(80);
        `CHK("count", n, st.got.size())
    endtask
    task automatic t_walk();
        int n;
        int kk[7] = '{9, 1, 5, 4, 2, 4, 3};
        bit ser[7] = '{1, 1, 1, 0, 1, 1, 0};
        logic [2:0] mm[7] = '{3'h1, 3'h2, 3'h2, 3'h1, 3'h3, 3'h1, 3'h4};
        logic [7:0] cc[7] = '{8'h02, 8'h03, 8'h03, 8'h02, 8'h07, 8'h02, 8'h0b};
        for (int i = 0; i < 7; i++) begin
            n = st.got.size();
            key(kk[i], ser[i]);
            if (i == 0) begin
                `CHK("count", n, st.got.size())
            end else begin
                expect_tx(n, cc[i]);
            end
            `CHK("menu", mm[i], display.menu)
        end
    endtask
    task automatic t_status();
        int n;
        logic [1:0] seen[$];
        n = st.got.size();
        press(0);
        `CHK("menu", menu_pkg::ST_STATUS, display.menu)
        seen.push_back(display.screen);
        for (int t = 0; t < 300 && display.menu === menu_pkg::ST_STATUS; t++) begin
            cyc(1);
            if (display.menu === menu_pkg::ST_STATUS && display.screen !== seen[$]) begin
                seen.push_back(display.screen);
            end
        end
        `CHK("screens", 4, seen.size())
        `CHK("last", menu_pkg::SCR_CHARS, seen[$])
        expect_tx(n, menu_pkg::CMD_UTILITY);
        `CHK("menu", menu_pkg::ST_UTILITY, display.menu)
    endtask
    task automatic t_lock();
        int n;
        n = st.got.size();
        press(1);
        `CHK("lock", 1'b1, display.locked)
        expect_tx(n, menu_pkg::CMD_LOCK);
        press(3);
        st.send(8'h34);
        cyc(8);
        `CHK("menu", menu_pkg::ST_UTILITY, display.menu)
        `CHK("lock", 1'b1, display.locked)
        n = st.got.size();
        st.send(menu_pkg::CHAR_SYNC);
        expect_tx(n, menu_pkg::CMD_LOCK);
        n = st.got.size();
        st.send(8'h32);
        cyc(8);
        `CHK("lock", 1'b0, display.locked)
        expect_tx(n, menu_pkg::CMD_UTILITY);
    endtask
    task automatic t_beep();
        int n;
        int bursts = 0;
        int low = 20;
        @(posedge core_clk);
        slow <= 1'b1;
        st.send(menu_pkg::CHAR_THREE);
        repeat (120) begin
            cyc(1);
            if (speaker === 1'b1 && low >= 5) bursts++;
            low = (speaker === 1'b1) ? 0 : low + 1;
        end
        `CHK("beeps", 3, bursts)
        `CHK("menu", menu_pkg::ST_UTILITY, display.menu)
        n = st.got.size();
        press(3);
        expect_tx(n, menu_pkg::CMD_MAIN);
        `CHK("menu", menu_pkg::ST_MAIN, display.menu)
    endtask
    initial begin
        rst = 1'b1;
        button = 4'h0;
        slow = 1'b0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_logo();
        t_walk();
        t_status();
        t_lock();
        t_beep();
        wrap_up();
    end
    // Whole run needs about 550 cycles
    initial begin
        #20000;
        err_total++;
        wrap_up();
    end
endmodule
